// [ptpcap_pkg.sv]
// ptpcap_pkg: constants, register map and types of the gpio timestamp capture block
// assumes a 32-bit ahb-lite register bus and a 100 MHz hclk
package ptpcap_pkg;

  // block dimensions
  localparam int NGPIO = 8;
  localparam int ADDR_W = 12;
  localparam int SEC_W = 32;
  localparam int NS_W = 30;
  localparam int UPPER_W = 16;
  localparam int BANK_W = 3;
  localparam int GSEL_W = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SELECT = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_MANUAL = 12'h108;
  localparam logic [ADDR_W-1:0] OFF_CFG = 12'h15C;
  localparam logic [ADDR_W-1:0] OFF_RISE_SEC = 12'h16C;
  localparam logic [ADDR_W-1:0] OFF_RISE_NS = 12'h170;
  localparam logic [ADDR_W-1:0] OFF_FALL_SEC = 12'h178;
  localparam logic [ADDR_W-1:0] OFF_FALL_NS = 12'h17C;
  localparam logic [ADDR_W-1:0] OFF_UPPER = 12'h180;

  // bank codes of the shared port/gpio address space
  localparam logic [BANK_W-1:0] BANK_PORT = 3'h2;
  localparam logic [BANK_W-1:0] BANK_GPIO = 3'h3;

  // field positions
  localparam int CFG_RISE_EN_LSB = 0;
  localparam int CFG_FALL_EN_LSB = 8;
  localparam int CFG_RISE_LOCK_LSB = 16;
  localparam int CFG_FALL_LOCK_LSB = 24;
  localparam int SEL_BANK_LSB = 0;
  localparam int SEL_GPIO_LSB = 8;
  localparam int STS_RISE_LSB = 0;
  localparam int STS_FALL_LSB = 8;

  // reset values
  localparam logic [31:0] CFG_RST = 32'hFFFF_0000;
  localparam logic [UPPER_W-1:0] UPPER_RST = 16'h0000;
  localparam logic [SEC_W-1:0] SEC_RST = 32'h0000_0000;
  localparam logic [NS_W-1:0] NS_RST = 30'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // timing: gpio level must stand this long before it counts
  localparam int CLK_PERIOD_NS = 10;
  localparam int GPIO_MIN_LEVEL_NS = 40;
  localparam int GPIO_FILT_RAW = (GPIO_MIN_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GPIO_FILT_CYC = (GPIO_FILT_RAW < 1) ? 1 : GPIO_FILT_RAW;

  // bus slave states
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_RD_WAIT
  } ptpcap_bus_st_t;

  // offset match for a bank-qualified register
  function automatic logic ptpcap_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] off,
                                      input logic [BANK_W-1:0] bank,
                                      input logic [BANK_W-1:0] need);
    ptpcap_hit = (addr == off) && (bank == need);
  endfunction

endpackage

// [ptpcap_edge_filt.sv]
// ptpcap_edge_filt: synchroniser, level filter and edge pulses for the gpio inputs
// assumes asynchronous pin inputs and a single hclk domain
`timescale 1ns/1ps

module ptpcap_edge_filt
  import ptpcap_pkg::*;
#(
  parameter int W = NGPIO,
  parameter int FILT = GPIO_FILT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pins
  input wire logic [W-1:0] pin,
  // one-cycle edge pulses
  output logic [W-1:0] rise_p,
  output logic [W-1:0] fall_p
);

  localparam int CW = $clog2(FILT + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;

  logic [W-1:0] sync1_q; // first stage, read only by sync2_q
  logic [W-1:0] sync2_q; // safe sampled pin
  logic [W-1:0] level_q; // filtered level
  logic [CW-1:0] cnt_q [W]; // cycles the new level has stood

  // two-flop synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  // a new level is accepted only after standing FILT samples, so short glitches never
  // make an edge; the trade is FILT-1 cycles more capture latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= '0;
      rise_p <= '0;
      fall_p <= '0;
      for (int i = 0; i < W; i++) cnt_q[i] <= CNT_ZERO;
    end else begin
      for (int i = 0; i < W; i++) begin
        rise_p[i] <= 1'b0;
        fall_p[i] <= 1'b0;
        if (sync2_q[i] == level_q[i]) begin
          cnt_q[i] <= CNT_ZERO; // level unchanged, restart
        end else if (cnt_q[i] == CNT_LAST) begin
          level_q[i] <= sync2_q[i];
          cnt_q[i] <= CNT_ZERO;
          rise_p[i] <= sync2_q[i];
          fall_p[i] <= ~sync2_q[i];
        end else begin
          cnt_q[i] <= cnt_q[i] + CW'(1);
        end
      end
    end
  end

endmodule // ptpcap_edge_filt

// [ptpcap_top.sv]
// ptpcap_top: gpio timestamp capture unit with one-step upper seconds register
// assumes an ahb-lite master on hclk and a protocol clock value from the same domain
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps

module ptpcap_top
  import ptpcap_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // protocol clock value
  input wire logic [SEC_W-1:0] ptp_sec,
  input wire logic [NS_W-1:0] ptp_ns,
  // gpio pins
  input wire logic [NGPIO-1:0] gpio_in,
  // status and one-step value
  output logic [NGPIO-1:0] rise_capture_status,
  output logic [NGPIO-1:0] fall_capture_status,
  output logic [UPPER_W-1:0] upper_seconds_value
);

  // bus state
  ptpcap_bus_st_t bus_st_q; // read wait tracking
  logic [ADDR_W-1:0] addr_q; // latched data phase address
  logic wr_pend_q; // write data phase in progress
  logic [31:0] rd_d; // read mux

  // registers
  logic [31:0] gpio_capture_config_q; // enables and locks
  logic [BANK_W-1:0] bank_q; // bank selector
  logic [GSEL_W-1:0] gsel_q; // gpio selector

  // capture storage, one word pair per gpio and edge
  logic [SEC_W-1:0] rise_sec_q [NGPIO];
  logic [NS_W-1:0] rise_ns_q [NGPIO];
  logic [SEC_W-1:0] fall_sec_q [NGPIO];
  logic [NS_W-1:0] fall_ns_q [NGPIO];

  // event wiring
  logic [NGPIO-1:0] rise_p; // filtered rising edges
  logic [NGPIO-1:0] fall_p; // filtered falling edges
  logic [NGPIO-1:0] man_rise; // manual rise capture command
  logic [NGPIO-1:0] man_fall; // manual fall capture command
  logic [NGPIO-1:0] rise_take; // rising captures that land
  logic [NGPIO-1:0] fall_take; // falling captures that land
  logic [NGPIO-1:0] rise_clr; // w1c of rise status
  logic [NGPIO-1:0] fall_clr; // w1c of fall status
  logic addr_ok; // address phase accepted
  logic [NGPIO-1:0] rise_en, fall_en, rise_lock, fall_lock;

  // pins are synchronised and filtered before any edge is seen
  ptpcap_edge_filt #(
    .W(NGPIO),
    .FILT(GPIO_FILT_CYC)
  ) u_edge (
    .clk(hclk),
    .rst_n(hresetn),
    .pin(gpio_in),
    .rise_p(rise_p),
    .fall_p(fall_p)
  );

  assign addr_ok = hsel && htrans[1] && hready;
  assign rise_en = gpio_capture_config_q[CFG_RISE_EN_LSB +: NGPIO];
  assign fall_en = gpio_capture_config_q[CFG_FALL_EN_LSB +: NGPIO];
  assign rise_lock = gpio_capture_config_q[CFG_RISE_LOCK_LSB +: NGPIO];
  assign fall_lock = gpio_capture_config_q[CFG_FALL_LOCK_LSB +: NGPIO];

  // ahb-lite slave: writes complete at once, reads take one wait state so that a
  // selector written just before is already in effect when the read mux is sampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_q <= BUS_IDLE;
      addr_q <= '0;
      wr_pend_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= WORD_ZERO;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      case (bus_st_q)
        BUS_IDLE: begin
          if (addr_ok) begin
            addr_q <= haddr;
            if (!hwrite) begin
              hreadyout <= 1'b0; // insert wait state
              bus_st_q <= BUS_RD_WAIT;
            end
          end
        end
        BUS_RD_WAIT: begin
          hrdata <= rd_d;
          hreadyout <= 1'b1;
          bus_st_q <= BUS_IDLE;
        end
        default: begin
          bus_st_q <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // responses are always okay, unmapped words read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hresp <= 1'b0;
    else hresp <= 1'b0;
  end

  // read mux; capture words follow the bank and gpio selectors
  always_comb begin
    rd_d = WORD_ZERO;
    if (addr_q == OFF_SELECT) begin
      rd_d[SEL_BANK_LSB +: BANK_W] = bank_q;
      rd_d[SEL_GPIO_LSB +: GSEL_W] = gsel_q;
    end else if (addr_q == OFF_STATUS) begin
      rd_d[STS_RISE_LSB +: NGPIO] = rise_capture_status;
      rd_d[STS_FALL_LSB +: NGPIO] = fall_capture_status;
    end else if (ptpcap_hit(addr_q, OFF_CFG, bank_q, BANK_GPIO)) begin
      rd_d = gpio_capture_config_q;
    end else if (ptpcap_hit(addr_q, OFF_RISE_SEC, bank_q, BANK_GPIO)) begin
      rd_d = rise_sec_q[gsel_q];
    end else if (ptpcap_hit(addr_q, OFF_RISE_NS, bank_q, BANK_GPIO)) begin
      rd_d[NS_W-1:0] = rise_ns_q[gsel_q];
    end else if (ptpcap_hit(addr_q, OFF_FALL_SEC, bank_q, BANK_GPIO)) begin
      rd_d = fall_sec_q[gsel_q];
    end else if (ptpcap_hit(addr_q, OFF_FALL_NS, bank_q, BANK_GPIO)) begin
      rd_d[NS_W-1:0] = fall_ns_q[gsel_q];
    end else if (ptpcap_hit(addr_q, OFF_UPPER, bank_q, BANK_PORT)) begin
      rd_d[UPPER_W-1:0] = upper_seconds_value;
    end
  end

  // bank and gpio selector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_q <= '0;
      gsel_q <= '0;
    end else if (wr_pend_q && addr_q == OFF_SELECT) begin
      bank_q <= hwdata[SEL_BANK_LSB +: BANK_W];
      gsel_q <= hwdata[SEL_GPIO_LSB +: GSEL_W];
    end
  end

  // capture configuration: enables reset off, locks reset on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_capture_config_q <= CFG_RST;
    end else if (wr_pend_q && ptpcap_hit(addr_q, OFF_CFG, bank_q, BANK_GPIO)) begin
      gpio_capture_config_q <= hwdata;
    end
  end

  // upper seconds: one shared copy for every port, never advanced by the clock;
  // seconds rollover is deliberately not wired here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upper_seconds_value <= UPPER_RST;
    end else if (wr_pend_q && ptpcap_hit(addr_q, OFF_UPPER, bank_q, BANK_PORT)) begin
      upper_seconds_value <= hwdata[UPPER_W-1:0];
    end
  end

  // manual commands and status clears decode straight from the write data phase
  always_comb begin
    man_rise = '0;
    man_fall = '0;
    rise_clr = '0;
    fall_clr = '0;
    if (wr_pend_q && addr_q == OFF_MANUAL) begin
      man_rise = hwdata[STS_RISE_LSB +: NGPIO];
      man_fall = hwdata[STS_FALL_LSB +: NGPIO];
    end
    if (wr_pend_q && addr_q == OFF_STATUS) begin
      rise_clr = hwdata[STS_RISE_LSB +: NGPIO];
      fall_clr = hwdata[STS_FALL_LSB +: NGPIO];
    end
  end

  // a capture lands unless its lock is on and the status still shows an unread one
  assign rise_take = ((rise_p & rise_en) | man_rise) & ~(rise_lock & rise_capture_status);
  assign fall_take = ((fall_p & fall_en) | man_fall) & ~(fall_lock & fall_capture_status);

  // sticky status; a new capture in the clearing cycle wins over the clear unless its lock is on and the status bit is still set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_capture_status <= '0;
      fall_capture_status <= '0;
    end else begin
      rise_capture_status <= (rise_capture_status & ~rise_clr) | rise_take;
      fall_capture_status <= (fall_capture_status & ~fall_clr) | fall_take;
    end
  end

  // capture storage: seconds and nanoseconds come from the same cycle's sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NGPIO; i++) begin
        rise_sec_q[i] <= SEC_RST;
        rise_ns_q[i] <= NS_RST;
        fall_sec_q[i] <= SEC_RST;
        fall_ns_q[i] <= NS_RST;
      end
    end else begin
      for (int i = 0; i < NGPIO; i++) begin
        if (rise_take[i]) begin
          rise_sec_q[i] <= ptp_sec;
          rise_ns_q[i] <= ptp_ns;
        end
        if (fall_take[i]) begin
          fall_sec_q[i] <= ptp_sec;
          fall_ns_q[i] <= ptp_ns;
        end
      end
    end
  end

  // ---- assertions ----
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // read handshake: accepted read, one wait, then ready
  sequence rd_accept_s;
    addr_ok && !hwrite && hreadyout;
  endsequence
  sequence rd_done_s;
    !hreadyout ##1 hreadyout;
  endsequence

  logic upper_wr; // helper: upper seconds write
  assign upper_wr = wr_pend_q && ptpcap_hit(addr_q, OFF_UPPER, bank_q, BANK_PORT);

  upper_load_a: assert property (upper_wr |=> upper_seconds_value == $past(hwdata[UPPER_W-1:0]))
    else $error("upper seconds not loaded from host write");

  upper_static_a: assert property (!upper_wr |=> $stable(upper_seconds_value))
    else $error("upper seconds changed without host write");

  // a locked edge finds the status already set, so status must show after any enabled edge that meets no clear in its cycle
  rise_set_a: assert property ((rise_p[2] && rise_en[2] && !rise_clr[2]) |=> rise_capture_status[2])
    else $error("enabled rising edge did not set status");

  fall_set_a: assert property ((fall_p[5] && fall_en[5] && !fall_clr[5]) |=> fall_capture_status[5])
    else $error("enabled falling edge did not set status");

  cfg_reset_a: assert property ($rose(hresetn) |-> gpio_capture_config_q == CFG_RST)
    else $error("capture config reset value wrong");

  lock_hold_a: assert property ((rise_lock[2] && rise_capture_status[2])
                                 |=> $stable(rise_sec_q[2]) && $stable(rise_ns_q[2]))
    else $error("locked capture was overwritten");

  same_sample_a: assert property (fall_take[5] |=> fall_sec_q[5] == $past(ptp_sec)
                                   && fall_ns_q[5] == $past(ptp_ns))
    else $error("capture halves from different samples");

  manual_cap_a: assert property ((man_rise[7] && !(rise_lock[7] && rise_capture_status[7]))
                                  |=> rise_capture_status[7] && rise_sec_q[7] == $past(ptp_sec))
    else $error("manual capture did not fill registers");

  rd_timing_a: assert property (rd_accept_s |=> rd_done_s)
    else $error("read answer not after one wait state");

  ns_top_zero_a: assert property ((bus_st_q == BUS_RD_WAIT && addr_q == OFF_RISE_NS)
                                   |=> hrdata[31:30] == 2'b00)
    else $error("nanoseconds reserved bits not zero");

  bank_gate_a: assert property ((bus_st_q == BUS_RD_WAIT && addr_q == OFF_FALL_SEC
                                 && bank_q != BANK_GPIO) |=> hrdata == WORD_ZERO)
    else $error("capture word visible outside gpio bank");

  edge_seen_a: assert property ($rose(rise_p[5]) |=> !rise_p[5])
    else $error("edge pulse longer than one cycle");

endmodule // ptpcap_top

// [ptpcap_pin_model.sv]
// ptpcap_pin_model: behavioural source for the eight timestamp gpio pins
// assumes the pins are already configured as inputs on the device side
`timescale 1ns/1ps

module ptpcap_pin_model
  import ptpcap_pkg::*;
(
  // pins toward the capture block
  output logic [NGPIO-1:0] pins
);
  // pins idle low; a gpio is only ever driven as an input here
  initial begin
    pins = '0;
  end

  // move one pin to a level and leave it settled for well over four clocks
  // non-blocking so a change on a clock edge is seen by the synchroniser one edge later
  task automatic level(input int idx, input logic lvl);
    pins[idx] <= lvl;
    #100;
  endtask

  // pulse one pin to lvl for width_ns, then hold the old level before returning
  // a width under 40 ns is a deliberate glitch the block must ignore
  task automatic pulse(input int idx, input logic lvl, input int width_ns);
    pins[idx] <= lvl;
    #(width_ns);
    pins[idx] <= ~lvl;
    #60;
  endtask
endmodule // ptpcap_pin_model

// [ptp_gpio_timestamp_capture_test.sv]
// ptp_gpio_timestamp_capture_test: self-checking bench for the gpio capture block
// assumes ptpcap_top with its single ahb-lite slave and the pin model beside it
`timescale 1ns/1ps

module ptp_gpio_timestamp_capture_test;
  import ptpcap_pkg::*;
  // seconds start 512 below the top so the lower count wraps at cycle 512, late in the run
  localparam logic [31:0] SEC_OFS = 32'hFFFF_FE00;
  // bus signals
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rdv, capn;
  // protocol time, pins and outputs
  logic [SEC_W-1:0] ptp_sec;
  logic [NS_W-1:0] ptp_ns;
  logic [NGPIO-1:0] gpio_in, rsts, fsts;
  logic [UPPER_W-1:0] upper;
  int bad_count, n_checks, cyc;

  // device under test; the one slave drives hready
  ptpcap_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ptp_sec(ptp_sec),
    .ptp_ns(ptp_ns), .gpio_in(gpio_in), .rise_capture_status(rsts),
    .fall_capture_status(fsts), .upper_seconds_value(upper));
  ptpcap_pin_model pm (.pins(gpio_in));

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // cycle count doubles as protocol time; sec and ns always differ by SEC_OFS
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    ptp_sec <= SEC_OFS + cyc;
    ptp_ns <= cyc[29:0];
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end

  // count and report one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task summarize();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one single ahb-lite transfer; waits on hready only, read data lands in rdv
  task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  // bank and gpio selector
  task sel(input logic [2:0] b, input logic [2:0] g);
    bus(1'b1, OFF_SELECT, {21'h0, g, 5'h0, b});
  endtask

  // bounded wait for one status bit
  task wait_sts(input int i, input logic fall);
    for (int k = 0; k < 40; k++) begin
      if ((fall ? fsts[i] : rsts[i]) === 1'b1) break;
      @(posedge hclk);
    end
  endtask

  // read a capture pair, seconds first, without waiting on its status; ns lands in capn
  task pair(input logic [2:0] g, input logic fall);
    logic [31:0] s;
    sel(3'h3, g);
    bus(1'b0, fall ? OFF_FALL_SEC : OFF_RISE_SEC, WORD_ZERO);
    s = rdv;
    bus(1'b0, fall ? OFF_FALL_NS : OFF_RISE_NS, WORD_ZERO);
    capn = rdv;
    chk({30'h0, rdv[31:30]}, 32'h0, "ns top bits");
    chk(s, SEC_OFS + rdv, "sec and ns from one sample");
  endtask

  // captured time must sit within the documented sync and filter latency
  task win(input int t0, input int lo, input int hi);
    chk({31'h0, capn >= 32'(t0 + lo) && capn <= 32'(t0 + hi)}, 32'h1, "capture time");
  endtask

  // reset values of config, capture words and outputs
  task t_reset();
    logic [ADDR_W-1:0] offs [4];
    offs = '{OFF_RISE_SEC, OFF_RISE_NS, OFF_FALL_SEC, OFF_FALL_NS};
    chk({16'h0, fsts, rsts}, 32'h0, "status at reset");
    sel(3'h3, 3'h0);
    bus(1'b0, OFF_CFG, WORD_ZERO);
    chk(rdv, 32'hFFFF_0000, "config reset");
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, offs[k], WORD_ZERO);
      chk(rdv, 32'h0, "capture reset");
    end
  endtask

  // upper seconds: wrong bank ignored, right bank written and read back
  task t_upper();
    chk({16'h0, upper}, 32'h0, "upper reset");
    bus(1'b1, OFF_UPPER, 32'h0000_1234);
    @(posedge hclk); // the write lands on the edge the task returns on
    chk({16'h0, upper}, 32'h0, "upper wrong bank");
    sel(3'h2, 3'h0);
    bus(1'b1, OFF_UPPER, 32'hFFFF_A5C3);
    @(posedge hclk);
    chk({16'h0, upper}, 32'h0000_A5C3, "upper write");
    bus(1'b0, OFF_UPPER, WORD_ZERO);
    chk({16'h0, rdv[15:0]}, 32'h0000_A5C3, "upper read");
  endtask

  // rising capture, lock holding the first, clear, then unlocked overwrite
  task t_rise();
    int t0;
    logic [31:0] c1;
    sel(3'h3, 3'h2);
    bus(1'b1, OFF_CFG, 32'hFFFF_0004);
    t0 = cyc;
    pm.pulse(2, 1'b1, 80);
    wait_sts(2, 1'b0);
    chk({16'h0, fsts, rsts}, 32'h0004, "rise status");
    pair(3'h2, 1'b0);
    win(t0, 4, 14);
    c1 = capn;
    pm.pulse(2, 1'b1, 80);
    repeat (20) @(posedge hclk);
    pair(3'h2, 1'b0);
    chk(capn, c1, "locked capture kept");
    bus(1'b1, OFF_STATUS, 32'h0000_0004);
    @(posedge hclk); // clear takes effect on the data phase edge
    chk({24'h0, rsts}, 32'h0, "status clear");
    bus(1'b1, OFF_CFG, 32'hFFFB_0004);
    pm.pulse(2, 1'b1, 80);
    wait_sts(2, 1'b0);
    pair(3'h2, 1'b0);
    c1 = capn;
    pm.pulse(2, 1'b1, 80);
    repeat (20) @(posedge hclk);
    pair(3'h2, 1'b0);
    chk({31'h0, capn > c1}, 32'h1, "unlocked overwrite");
  endtask

  // falling capture lands in its own pair and status field
  task t_fall();
    int t0;
    bus(1'b1, OFF_STATUS, 32'h0000_FFFF);
    bus(1'b1, OFF_CFG, 32'hFFFF_2000);
    pm.level(5, 1'b1);
    t0 = cyc;
    pm.pulse(5, 1'b0, 80);
    wait_sts(5, 1'b1);
    chk({16'h0, fsts, rsts}, 32'h2000, "fall status");
    pair(3'h5, 1'b1);
    win(t0, 4, 14);
  endtask

  // glitch and disabled gpio leave no capture
  task t_quiet();
    bus(1'b1, OFF_STATUS, 32'h0000_FFFF);
    bus(1'b1, OFF_CFG, 32'hFFFF_0008);
    pm.pulse(3, 1'b1, 30);
    pm.pulse(6, 1'b1, 80);
    repeat (20) @(posedge hclk);
    chk({16'h0, fsts, rsts}, 32'h0, "no capture");
  endtask

  // manual capture of gpio 7 on both edges
  task t_manual();
    int t0;
    bus(1'b1, OFF_CFG, 32'hFFFF_8080);
    t0 = cyc;
    bus(1'b1, OFF_MANUAL, 32'h0000_8080);
    wait_sts(7, 1'b0);
    chk({16'h0, fsts, rsts}, 32'h8080, "manual status");
    pair(3'h7, 1'b0);
    win(t0, 0, 10);
    pair(3'h7, 1'b1);
    win(t0, 0, 10);
  endtask

  // unmapped address and capture word outside bank 3 read zero, still okay
  task t_unmapped();
    bus(1'b0, 12'h1F0, WORD_ZERO);
    chk(rdv, 32'h0, "unmapped read");
    sel(3'h2, 3'h7);
    bus(1'b0, OFF_RISE_SEC, WORD_ZERO);
    chk(rdv, 32'h0, "capture outside bank");
    bus(1'b0, OFF_FALL_SEC, WORD_ZERO);
    chk(rdv, 32'h0, "fall capture outside bank");
    chk({31'h0, hresp}, 32'h0, "response okay");
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = '0;
    hwrite = 1'b0;
    hwdata = '0;
    cyc = 0;
    ptp_sec = SEC_OFS;
    ptp_ns = '0;
    bad_count = 0;
    n_checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_upper();
    t_rise();
    t_fall();
    t_quiet();
    t_manual();
    t_unmapped();
    // lower seconds have wrapped by now; the upper value must not have moved
    while (cyc < 600) @(posedge hclk);
    chk({16'h0, upper}, 32'h0000_A5C3, "upper after wrap");
    summarize();
  end
endmodule // ptp_gpio_timestamp_capture_test
